//--- pkg/tscg_pkg.sv
// constants shared by the code gate sequencer
package tscg_pkg;
    // channel indices
    localparam int CH_M = 0;
    localparam int CH_X = 1;
    localparam int CH_Y = 2;
    localparam int CH_N = 3;
    localparam int SYNC_W = 6;

    // timing, in microseconds and in reference edges
    localparam int REF_PERIOD_US = 100;
    localparam int GATE_TIME_US = 7400;
    localparam int GATE_REF_EDGES = GATE_TIME_US / REF_PERIOD_US;
    localparam int DIV_LONG = 10;
    localparam int DIV_SHORT = 5;
    localparam logic [2:0] DIV5_LAST = 3'(DIV_SHORT - 1);
    localparam logic [2:0] END_DIV5_PHASE = 3'((GATE_REF_EDGES % DIV_LONG) / 2);
    localparam logic [2:0] CODE_LAST = 3'h7;

    // register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_IGNORED = 4'h8;
    localparam logic [3:0] OFS_GATES_DONE = 4'hc;

    // field positions
    localparam int CTRL_SPACING_500_BIT = 0;
    localparam int CTRL_SINGLE_PULSE_BIT = 1;
    localparam int STATUS_GATE_LSB = 0;
    localparam int STATUS_HOLD_LSB = 4;
    localparam int STATUS_CODE_LSB = 8;
    localparam int IGNORED_LSB = 0;

    // reset values
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [15:0] GATES_DONE_RESET = 16'h0000;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- pkg/tscg_count_if.sv
// link between sequencer and divider/code counter
interface tscg_count_if;
    logic ref_tick;
    logic clear;
    logic spacing_500;
    logic [2:0] code_count;
    logic gate_end;

    modport ctl (output ref_tick, output clear, output spacing_500, input code_count, input gate_end);
    modport cnt (input ref_tick, input clear, input spacing_500, output code_count, output gate_end);
endinterface

//--- src/tscg_edge_sync.sv
// two-stage synchroniser with rising-edge pulse per bit
module tscg_edge_sync
    import tscg_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // asynchronous levels in
    input wire logic [SYNC_W-1:0] din,
    // synchronised level and rising edge out
    output logic [SYNC_W-1:0] level,
    output logic [SYNC_W-1:0] rise
);
    logic [SYNC_W-1:0] meta_ff;
    logic [SYNC_W-1:0] sync_ff;
    logic [SYNC_W-1:0] last_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
            last_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise = sync_ff & ~last_ff; // R21
endmodule

//--- src/tscg_code_counter.sv
// divide-by-2/5 prescaler and three-bit code counter
module tscg_code_counter
    import tscg_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link to sequencer
    tscg_count_if.cnt cif
);
    logic half_ff;
    logic [2:0] div5_ff;
    logic [2:0] code_ff;
    logic end_ff;
    logic nxt_half;
    logic [2:0] nxt_div5;
    logic [2:0] nxt_code;
    logic div_carry;
    logic done;

    always_comb begin
        nxt_half = cif.spacing_500 ? 1'b0 : ~half_ff; // R8 R20
        div_carry = cif.spacing_500 | half_ff;
        nxt_div5 = div5_ff;
        nxt_code = code_ff;
        if (div_carry) begin
            nxt_div5 = (div5_ff == DIV5_LAST) ? 3'h0 : div5_ff + 3'h1; // R7
            if (div5_ff == DIV5_LAST) begin
                nxt_code = code_ff + 3'h1; // R6 R10
            end
        end
        done = cif.ref_tick && nxt_code == CODE_LAST && nxt_div5 == END_DIV5_PHASE && !nxt_half;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || cif.clear || done) begin
            half_ff <= 1'b0;
            div5_ff <= 3'h0;
            code_ff <= 3'h0; // R11
        end else if (cif.ref_tick) begin
            half_ff <= nxt_half;
            div5_ff <= nxt_div5;
            code_ff <= nxt_code;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            end_ff <= 1'b0;
        end else begin
            end_ff <= done && !cif.clear; // R11
        end
    end

    assign cif.code_count = code_ff;
    assign cif.gate_end = end_ff;
endmodule

//--- src/tscg_sequencer.sv
// code gate sequencer: toggles, blocking, timing gate, register slave
// Overview of operation
// (R1) After reset all three toggles idle, gates inactive, ready for triggers.
// (R2) Idle unblocked toggle goes active on its trigger, raising its gate.
// (R3) An active gate passes its channel's 10 kHz reference to the divider.
// (R4) The three gated references merge onto one shared line.
// (R5) Inactive gate lets none of its reference through; line idles low.
// (R6) At 1000 us spacing divide 10 kHz down to a 1 kHz count clock.
// (R7) Divide-by-five stage gives one output cycle per five inputs.
// (R8) Divide-by-ten is a divide-by-two toggle ahead of divide-by-five.
// (R9) Operator selects 500 us or 1000 us spacing; 1000 us normal.
// (R10) Three-bit binary code counter shows each count for one spacing period.
// (R11) Counter resets itself and ends the gate 7400 us after opening; at 500 us spacing the code ends it after 3700 us.
// (R12) Gate-end pulse reaches all toggles; only the active one changes.
// (R13) Active master gate holds the first-slave toggle against its trigger.
// (R14) Trigger source spaces first-slave trigger 7400 us after master trigger.
// (R15) Three holds, one per active gate, freeze their target toggle.
// (R16) Blocking is cyclic: master blocks X, X blocks Y, Y blocks master.
// (R17) When a channel's gate ends, the toggle it blocked is released.
// (R18) Eight-pulse mode: counter completion resets all three toggles.
// (R19) Single-pulse mode: master end resets slaves; first-slave end resets master.
// (R20) 500 us spacing bypasses divide-by-two, using divide-by-five only.
// (R21) Triggers and references synchronised; triggers become one-cycle edges.
// (R22) Trigger arriving blocked or already active is dropped, not queued.
module tscg_sequencer
    import tscg_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // triggers and references
    input wire logic master_trigger,
    input wire logic first_slave_trigger,
    input wire logic second_slave_trigger,
    input wire logic master_ref,
    input wire logic first_slave_ref,
    input wire logic second_slave_ref,
    // gates and holds
    output logic master_gate,
    output logic first_slave_gate,
    output logic second_slave_gate,
    output logic master_hold,
    output logic first_slave_hold,
    output logic second_slave_hold,
    // shared reference and code outputs
    output logic shared_ref,
    output logic [2:0] code_count,
    output logic gate_end,
    // axi4-lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    tscg_count_if cif ();

    logic [SYNC_W-1:0] sync_level;
    logic [SYNC_W-1:0] sync_rise;
    logic [CH_N-1:0] trig_rise;
    logic [CH_N-1:0] ref_level;
    logic [CH_N-1:0] ref_rise;

    logic [CH_N-1:0] active_ff;
    logic [CH_N-1:0] prev_active_ff;
    logic [CH_N-1:0] nxt_active;
    logic [CH_N-1:0] hold;
    logic [CH_N-1:0] fire;
    logic [CH_N-1:0] dropped;
    logic [CH_N-1:0] falling;
    logic shared_ref_ff;
    logic [2:0] code_ff;
    logic gate_end_ff;

    logic [1:0] ctrl_ff;
    logic [CH_N-1:0] ignored_ff;
    logic [CH_N-1:0] nxt_ignored;
    logic [15:0] gates_done_ff;

    logic aw_full_ff;
    logic [3:0] awaddr_ff;
    logic w_full_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic aw_hs;
    logic w_hs;
    logic b_hs;
    logic ar_hs;
    logic r_hs;
    logic do_write;
    logic nxt_aw_full;
    logic nxt_w_full;
    logic nxt_r_busy;
    logic [CH_N-1:0] w1c;

    function automatic logic addr_mapped(input logic [3:0] addr);
        return addr == OFS_CTRL || addr == OFS_STATUS || addr == OFS_IGNORED || addr == OFS_GATES_DONE;
    endfunction

    // synchronise triggers (low bits) and references (high bits)
    tscg_edge_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({second_slave_ref, first_slave_ref, master_ref,
              second_slave_trigger, first_slave_trigger, master_trigger}),
        .level(sync_level),
        .rise(sync_rise)
    );

    assign trig_rise = sync_rise[CH_N-1:0]; // R21
    assign ref_level = sync_level[SYNC_W-1:CH_N];
    assign ref_rise = sync_rise[SYNC_W-1:CH_N];

    tscg_code_counter u_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .cif(cif)
    );

    assign cif.ref_tick = |(ref_rise & active_ff); // R3 R4 R5
    assign cif.clear = |fire;
    assign cif.spacing_500 = ctrl_ff[CTRL_SPACING_500_BIT]; // R9 R20

    // cyclic blocking from each active gate
    assign hold[CH_X] = active_ff[CH_M]; // R13 R15 R16
    assign hold[CH_Y] = active_ff[CH_X]; // R15 R16
    assign hold[CH_M] = active_ff[CH_Y]; // R15 R16

    // toggle next state
    always_comb begin
        falling = prev_active_ff & ~active_ff;
        fire = trig_rise & ~active_ff & ~hold; // R2 R22
        dropped = trig_rise & ~fire; // R22
        nxt_active = active_ff;
        if (cif.gate_end) begin
            nxt_active = '0; // R12 R17 R18
        end
        if (ctrl_ff[CTRL_SINGLE_PULSE_BIT]) begin
            if (falling[CH_M]) begin
                nxt_active[CH_X] = 1'b0; // R19
                nxt_active[CH_Y] = 1'b0; // R19
            end
            if (falling[CH_X]) begin
                nxt_active[CH_M] = 1'b0; // R19
            end
        end
        nxt_active = nxt_active | fire; // R2
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            active_ff <= '0; // R1
            prev_active_ff <= '0;
        end else begin
            active_ff <= nxt_active;
            prev_active_ff <= active_ff;
        end
    end

    // shared reference line and registered code outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shared_ref_ff <= 1'b0;
            code_ff <= 3'h0;
            gate_end_ff <= 1'b0;
        end else begin
            shared_ref_ff <= |(ref_level & active_ff); // R4 R5
            code_ff <= cif.code_count; // R10
            gate_end_ff <= cif.gate_end;
        end
    end

    // completed gate counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gates_done_ff <= GATES_DONE_RESET;
        end else if (cif.gate_end) begin
            gates_done_ff <= gates_done_ff + 16'h0001;
        end
    end

    // sticky dropped-trigger flags, set wins over clear
    always_comb begin
        w1c = '0;
        if (do_write && awaddr_ff == OFS_IGNORED && wstrb_ff[0]) begin
            w1c = wdata_ff[IGNORED_LSB +: CH_N];
        end
        nxt_ignored = (ignored_ff & ~w1c) | dropped;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ignored_ff <= '0;
        end else begin
            ignored_ff <= nxt_ignored;
        end
    end

    // bus handshakes
    assign aw_hs = s_axi_awvalid && awready_ff;
    assign w_hs = s_axi_wvalid && wready_ff;
    assign b_hs = bvalid_ff && s_axi_bready;
    assign ar_hs = s_axi_arvalid && arready_ff;
    assign r_hs = rvalid_ff && s_axi_rready;
    assign do_write = aw_full_ff && w_full_ff && !bvalid_ff;
    assign nxt_aw_full = (aw_full_ff || aw_hs) && !b_hs;
    assign nxt_w_full = (w_full_ff || w_hs) && !b_hs;
    assign nxt_r_busy = (rvalid_ff || ar_hs) && !r_hs;

    // write address and data capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            awaddr_ff <= 4'h0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            aw_full_ff <= nxt_aw_full;
            w_full_ff <= nxt_w_full;
            awready_ff <= !nxt_aw_full;
            wready_ff <= !nxt_w_full;
            if (aw_hs) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
        end
    end

    // write response and control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            ctrl_ff <= CTRL_RESET;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= addr_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
            if (awaddr_ff == OFS_CTRL && wstrb_ff[0]) begin
                ctrl_ff <= wdata_ff[1:0]; // R9
            end
        end else if (b_hs) begin
            bvalid_ff <= 1'b0;
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else begin
            arready_ff <= !nxt_r_busy;
            if (ar_hs) begin
                rvalid_ff <= 1'b1;
                rresp_ff <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
                rdata_ff <= 32'h0000_0000;
                case (s_axi_araddr)
                    OFS_CTRL: begin
                        rdata_ff[1:0] <= ctrl_ff;
                    end
                    OFS_STATUS: begin
                        rdata_ff[STATUS_GATE_LSB +: CH_N] <= active_ff;
                        rdata_ff[STATUS_HOLD_LSB +: CH_N] <= hold;
                        rdata_ff[STATUS_CODE_LSB +: 3] <= code_ff;
                    end
                    OFS_IGNORED: begin
                        rdata_ff[IGNORED_LSB +: CH_N] <= ignored_ff;
                    end
                    OFS_GATES_DONE: begin
                        rdata_ff[15:0] <= gates_done_ff;
                    end
                    default: begin
                        rdata_ff <= 32'h0000_0000;
                    end
                endcase
            end else if (r_hs) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // outputs
    assign master_gate = active_ff[CH_M];
    assign first_slave_gate = active_ff[CH_X];
    assign second_slave_gate = active_ff[CH_Y];
    assign master_hold = active_ff[CH_Y];
    assign first_slave_hold = active_ff[CH_M];
    assign second_slave_hold = active_ff[CH_X];
    assign shared_ref = shared_ref_ff;
    assign code_count = code_ff;
    assign gate_end = gate_end_ff;
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
endmodule

//--- verification/tscg_sequencer_checker.sv
// port assertions for the code gate sequencer
module tscg_checker
    import tscg_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // trigger
    input wire logic master_trigger,
    // gates and holds
    input wire logic master_gate,
    input wire logic first_slave_gate,
    input wire logic second_slave_gate,
    input wire logic master_hold,
    input wire logic first_slave_hold,
    input wire logic second_slave_hold,
    // shared outputs
    input wire logic shared_ref,
    input wire logic [2:0] code_count,
    input wire logic gate_end
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wire any_gate = master_gate | first_slave_gate | second_slave_gate;
    sequence s_idle3;
        !any_gate [*3];
    endsequence
    sequence s_m_fire;
        $rose(master_trigger) && !master_gate && !master_hold && !second_slave_gate;
    endsequence
    property p_reset_idle;
        $rose(aresetn) |-> !any_gate && !gate_end && !shared_ref;
    endproperty
    property p_hold_x;
        first_slave_hold == master_gate;
    endproperty
    property p_cyclic;
        second_slave_hold == first_slave_gate && master_hold == second_slave_gate;
    endproperty
    property p_held;
        (first_slave_hold && !first_slave_gate |=> !first_slave_gate) and
        (second_slave_hold && !second_slave_gate |=> !second_slave_gate) and
        (master_hold && !master_gate |=> !master_gate);
    endproperty
    property p_end_drop;
        gate_end |-> !any_gate && $past(any_gate);
    endproperty
    property p_end_pulse;
        gate_end |=> !gate_end;
    endproperty
    property p_shared_idle;
        s_idle3 |-> !shared_ref;
    endproperty
    property p_code_idle;
        s_idle3 |-> code_count == 3'h0;
    endproperty
    property p_code_step;
        code_count != $past(code_count) |-> code_count == $past(code_count) + 3'h1 || code_count == 3'h0;
    endproperty
    property p_m_fire;
        s_m_fire |-> ##[1:6] master_gate;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("gates busy after reset");
    a_hold_x: assert property (p_hold_x) else $error("first slave hold differs from master gate");
    a_cyclic: assert property (p_cyclic) else $error("hold chain broken");
    a_held: assert property (p_held) else $error("held toggle changed state");
    a_end_drop: assert property (p_end_drop) else $error("gate end without gate drop");
    a_end_pulse: assert property (p_end_pulse) else $error("gate end longer than one cycle");
    a_shared_idle: assert property (p_shared_idle) else $error("shared reference active while idle");
    a_code_idle: assert property (p_code_idle) else $error("code count not cleared");
    a_code_step: assert property (p_code_step) else $error("code count skipped");
    a_m_fire: assert property (p_m_fire) else $error("master toggle did not fire");
endmodule

bind tscg_sequencer tscg_checker u_tscg_checker (.aclk, .aresetn, .master_trigger, .master_gate, .first_slave_gate,
    .second_slave_gate, .master_hold, .first_slave_hold, .second_slave_hold, .shared_ref, .code_count, .gate_end);

//--- verification/tscg_far_model.sv
// far-side model: reference generator and trigger source
module tscg_far_model
    import tscg_pkg::*;
#(
    parameter int REF_CLKS = 10
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // trigger requests
    input wire logic [CH_N-1:0] fire_req,
    // triggers and references
    output logic master_trigger,
    output logic first_slave_trigger,
    output logic second_slave_trigger,
    output logic master_ref,
    output logic first_slave_ref,
    output logic second_slave_ref
);
    logic [7:0] phase_ff;
    logic [CH_N-1:0] pend_ff;
    logic [2:0] wid_ff [CH_N];
    // references run free, rate shortened to keep gates short
    always_ff @(posedge aclk) begin
        if (!aresetn) phase_ff <= 8'h00;
        else if (phase_ff == 8'(REF_CLKS - 1)) phase_ff <= 8'h00;
        else phase_ff <= phase_ff + 8'h01;
    end
    // trigger launched while its own reference is low, held four cycles
    always_ff @(posedge aclk) begin
        for (int i = 0; i < CH_N; i++) begin
            if (!aresetn) begin
                pend_ff[i] <= 1'b0;
                wid_ff[i] <= 3'h0;
            end else if (pend_ff[i] && phase_ff == ((i == CH_X) ? 8'h00 : 8'(REF_CLKS / 2))) begin
                pend_ff[i] <= 1'b0;
                wid_ff[i] <= 3'h4;
            end else begin
                pend_ff[i] <= pend_ff[i] | fire_req[i];
                wid_ff[i] <= (wid_ff[i] != 3'h0) ? wid_ff[i] - 3'h1 : 3'h0;
            end
        end
    end
    assign master_ref = phase_ff < 8'(REF_CLKS / 2);
    // first slave anti-phase, second slave in phase with master, so a leak between first slave and the others shows on the shared line
    assign first_slave_ref = !master_ref;
    assign second_slave_ref = master_ref;
    assign master_trigger = wid_ff[CH_M] != 3'h0;
    assign first_slave_trigger = wid_ff[CH_X] != 3'h0;
    assign second_slave_trigger = wid_ff[CH_Y] != 3'h0;
endmodule

//--- verification/tb_time_shared_code_gate_sequencer.sv
// testbench for the code gate sequencer
module tb_time_shared_code_gate_sequencer import tscg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [CH_N-1:0] fire_req = 3'h0;
    logic master_trigger, first_slave_trigger, second_slave_trigger, master_ref, first_slave_ref, second_slave_ref;
    logic master_gate, first_slave_gate, second_slave_gate, master_hold, first_slave_hold, second_slave_hold;
    logic shared_ref, gate_end;
    logic [2:0] code_count, gates;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int chs [4] = '{CH_M, CH_X, CH_Y, CH_M};
    int xs [4] = '{CH_X, CH_Y, CH_M, CH_M};
    logic [2:0] ign [4] = '{3'h2, 3'h4, 3'h1, 3'h1};
    assign gates = {second_slave_gate, first_slave_gate, master_gate};
    always #20 aclk = ~aclk;
    tscg_sequencer u_tscg_sequencer (.aclk, .aresetn, .master_trigger, .first_slave_trigger, .second_slave_trigger,
        .master_ref, .first_slave_ref, .second_slave_ref, .master_gate, .first_slave_gate, .second_slave_gate,
        .master_hold, .first_slave_hold, .second_slave_hold, .shared_ref, .code_count, .gate_end,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    tscg_far_model #(.REF_CLKS(10)) u_tscg_far_model (.aclk, .aresetn, .fire_req, .master_trigger,
        .first_slave_trigger, .second_slave_trigger, .master_ref, .first_slave_ref, .second_slave_ref);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_go, w_go;
        @(posedge aclk);
        aw_go = 1'b1;
        w_go = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_go || w_go || s_axi_bvalid !== 1'b1) begin
            @(posedge aclk);
            if (aw_go && s_axi_awready === 1'b1) begin
                aw_go = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_go && s_axi_wready === 1'b1) begin
                w_go = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(er));
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp, input logic [1:0] er);
        logic ar_go;
        @(posedge aclk);
        ar_go = 1'b1;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (ar_go || s_axi_rvalid !== 1'b1) begin
            @(posedge aclk);
            if (ar_go && s_axi_arready === 1'b1) begin
                ar_go = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
        end
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        check(rd & mask, exp);
        check(32'(rsp), 32'(er));
    endtask
    task automatic fire(input int ch);
        @(posedge aclk);
        fire_req[ch] <= 1'b1;
        @(posedge aclk);
        fire_req[ch] <= 1'b0;
    endtask
    // one gate; when extra is below CH_N a second trigger lands mid-gate and must be dropped
    task automatic run_gate(input int ch, input int extra, input int exp_rises);
        logic prev;
        logic [2:0] top;
        int n;
        int rises;
        prev = 1'b0;
        top = 3'h0;
        n = 0;
        rises = 0;
        fire(ch);
        while (gates[ch] !== 1'b1 && n < 40) begin
            @(posedge aclk);
            n++;
        end
        check(32'(gates[ch]), 32'h1);
        while (gates[ch] === 1'b1) begin
            @(posedge aclk);
            if (shared_ref === 1'b1 && prev !== 1'b1) rises++;
            prev = shared_ref;
            if (code_count > top) top = code_count;
            if (extra < CH_N) fire_req[extra] <= (rises == 10);
        end
        check(32'(gate_end), 32'h1);
        check(32'(rises), 32'(exp_rises));
        check(32'(top), 32'h7);
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check(32'({gates, master_hold, first_slave_hold, second_slave_hold, shared_ref, code_count}), 0);
        rd_chk(OFS_CTRL, 32'hffff_ffff, 32'h0000_0000, RESP_OKAY);
        rd_chk(OFS_STATUS, 32'hffff_ffff, 32'h0000_0000, RESP_OKAY);
        wr(OFS_STATUS, 32'hffff_ffff, RESP_OKAY);
        rd_chk(OFS_STATUS, 32'hffff_ffff, 32'h0000_0000, RESP_OKAY);
        wr(4'h6, 32'h0000_0003, RESP_SLVERR);
        rd_chk(4'h6, 32'hffff_ffff, 32'h0000_0000, RESP_SLVERR);
        wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
        rd_chk(OFS_CTRL, 32'hffff_ffff, 32'h0000_0003, RESP_OKAY);
        wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            run_gate(chs[i], xs[i], 74);
            rd_chk(OFS_IGNORED, 32'h0000_0007, 32'(ign[i]), RESP_OKAY);
            check(32'(gates), 32'h0);
            wr(OFS_IGNORED, 32'h0000_0007, RESP_OKAY);
        end
        rd_chk(OFS_IGNORED, 32'h0000_0007, 32'h0000_0000, RESP_OKAY);
        wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
        run_gate(CH_X, CH_N, 37);
        wr(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
        fire(CH_M);
        repeat (100) @(posedge aclk);
        fire(CH_Y);
        repeat (20) @(posedge aclk);
        rd_chk(OFS_STATUS, 32'h0000_0077, 32'h0000_0035, RESP_OKAY);
        while (master_gate === 1'b1) @(posedge aclk);
        check(32'(second_slave_gate), 32'h0);
        rd_chk(OFS_GATES_DONE, 32'h0000_ffff, 32'h0000_0006, RESP_OKAY);
        final_report();
    end
endmodule
